// ### timer_prescaler.sv
`timescale 1ns/1ps
module timer_prescaler #(
   parameter int RESET_HOLD_CYCLES = timer_prescaler_pkg::HOLD_CYCLES
) (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   // external count pin
   input  wire logic                         ext_count_clock_pin,
   // core side
   input  wire logic                         option_write,
   input  wire timer_prescaler_pkg::option_t option_wdata,
   input  wire logic                         timer_write,
   input  wire logic [7:0]                   timer_wdata,
   input  wire logic                         watchdog_clear_op,
   input  wire logic                         sleep_req,
   // watchdog rc oscillator tick
   input  wire logic                         wdt_osc_tick,
   // fuse straps
   input  wire timer_prescaler_pkg::fuse_t   fuse_strap,
   // status
   output logic [7:0]                        timer_count_reg,
   output timer_prescaler_pkg::option_t      option_reg,
   output timer_prescaler_pkg::fuse_t        fuse_reg,
   output logic                              wdt_timeout_reg,
   output logic                              in_reset_reg,
   output logic                              sleeping_reg
);

   // internal state
   logic [1:0]  phase_reg;         // instruction cycle phase
   logic [7:0]  pre_reg;
   logic        src_prev_reg;      // previous source level
   logic        sample_reg;        // sampled timer input
   logic        edge_pend_reg;     // captured edge awaiting increment
   logic [1:0]  inhibit_reg;       // instruction cycles left to inhibit
   logic [7:0]  wdt_base_reg;      // watchdog base counter
   logic [17:0] hold_reg;          // reset hold counter

   // decode
   wire running      = !in_reset_reg && !sleeping_reg;
   wire to_timer     = !option_reg.prescaler_assign_select;
   wire [2:0] ratio  = option_reg.prescale_ratio_field;
   wire pin_level    = ext_count_clock_pin ^ option_reg.count_edge_select;
   wire src_level    = option_reg.count_source_select ? pin_level : phase_reg[1];
   wire src_rise     = src_level && !src_prev_reg;
   wire pre_tap      = pre_reg[ratio];
   wire timer_in     = to_timer ? pre_tap : src_level;
   wire sample_go    = running && (phase_reg == timer_prescaler_pkg::PHASE_TWO ||
                                   phase_reg == timer_prescaler_pkg::PHASE_FOUR);
   wire edge_seen    = sample_go && timer_in && !sample_reg;
   wire write_go     = running && timer_write;
   wire cycle_end    = running && phase_reg == timer_prescaler_pkg::PHASE_FOUR;
   wire wdt_on       = fuse_reg.watchdog_enable_fuse;
   wire wdt_clr      = running && watchdog_clear_op;
   wire base_wrap    = wdt_on && wdt_osc_tick && wdt_base_reg == timer_prescaler_pkg::WDT_BASE_LAST;
   wire [7:0] wmask  = (8'h01 << ratio) - 8'h01;
   wire wdt_fire     = base_wrap && (to_timer || (pre_reg & wmask) == wmask);
   wire dev_reset    = wdt_fire && !sleeping_reg;
   wire hold_done    = hold_reg == 18'(RESET_HOLD_CYCLES - 1);
   wire pre_clear    = dev_reset || (write_go && to_timer) ||
                       (wdt_clr && !to_timer);
   wire pre_step     = to_timer ? src_rise : base_wrap;
   wire inhibit_on   = inhibit_reg != timer_prescaler_pkg::INHIBIT_NONE;

   // phase counter, stopped in reset hold and sleep
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         phase_reg <= timer_prescaler_pkg::PHASE_ONE;
      else if (running)
         phase_reg <= phase_reg + 2'h1;
   end

   // shared scaler: cleared by reset, by a timer write while on the timer, or by a watchdog clear while on the watchdog
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pre_reg <= timer_prescaler_pkg::PRE_ZERO;
      else if (pre_clear)
         pre_reg <= timer_prescaler_pkg::PRE_ZERO;
      else if (pre_step)
         pre_reg <= pre_reg + 8'h01;
   end

   // source edge history
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         src_prev_reg <= 1'b0;
      else
         src_prev_reg <= src_level;
   end

   // synchroniser: capture on phase two and four, increment one clock later
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         // taken as high, so a level already high at reset is no edge
         sample_reg    <= 1'b1;
         edge_pend_reg <= 1'b0;
      end
      else if (dev_reset)
      begin
         // same after a watchdog reset, when the option word reverts
         sample_reg    <= 1'b1;
         edge_pend_reg <= 1'b0;
      end
      else
      begin
         if (sample_go)
            sample_reg <= timer_in;
         edge_pend_reg <= edge_seen;
      end
   end

   // timer count: write wins, then inhibited or pending increment
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         timer_count_reg <= 8'h00;
      else if (write_go)
         timer_count_reg <= timer_wdata;
      else if (edge_pend_reg && !inhibit_on && running)
         timer_count_reg <= timer_count_reg + 8'h01;
   end

   // increment inhibit after a timer write
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         inhibit_reg <= timer_prescaler_pkg::INHIBIT_NONE;
      else if (write_go)
         inhibit_reg <= timer_prescaler_pkg::INHIBIT_CYCLES;
      else if (cycle_end && inhibit_on)
         inhibit_reg <= inhibit_reg - 2'h1;
   end

   // configuration word, writable at any time while running
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         option_reg <= timer_prescaler_pkg::OPTION_RESET;
      else if (dev_reset)
         option_reg <= timer_prescaler_pkg::OPTION_RESET;
      else if (running && option_write)
         option_reg <= option_wdata;
   end

   // fuses follow the straps during reset hold, frozen afterwards
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         fuse_reg <= timer_prescaler_pkg::FUSE_RESET;
      else if (in_reset_reg)
         fuse_reg <= fuse_strap;
   end

   // watchdog base counter on its own oscillator tick
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         wdt_base_reg <= timer_prescaler_pkg::WDT_ZERO;
      else if (wdt_clr || dev_reset)
         wdt_base_reg <= timer_prescaler_pkg::WDT_ZERO;
      else if (wdt_on && wdt_osc_tick)
         wdt_base_reg <= wdt_base_reg + 8'h01;
   end

   // timeout pulse
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         wdt_timeout_reg <= 1'b0;
      else
         wdt_timeout_reg <= wdt_fire;
   end

   // reset hold timer: restarts on a watchdog reset while awake
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_reg     <= timer_prescaler_pkg::HOLD_ZERO;
         in_reset_reg <= 1'b1;
      end
      else if (dev_reset)
      begin
         hold_reg     <= timer_prescaler_pkg::HOLD_ZERO;
         in_reset_reg <= 1'b1;
      end
      else if (in_reset_reg)
      begin
         hold_reg     <= hold_reg + 18'h00001;
         in_reset_reg <= !hold_done;
      end
   end

   // sleep: only a timeout or the external reset ends it
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         sleeping_reg <= 1'b0;
      else if (sleeping_reg && wdt_fire)
         sleeping_reg <= 1'b0;
      else if (running && sleep_req)
         sleeping_reg <= 1'b1;
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_write_clears_pre: assert property (write_go && to_timer |=> pre_reg == 8'h00)
      else $error("timer write left scaler nonzero");
   a_wdt_clears_both: assert property (wdt_clr && !to_timer && !pre_step |=>
      pre_reg == 8'h00 && wdt_base_reg == 8'h00)
      else $error("watchdog clear missed scaler or counter");
   a_reset_zero_pre: assert property (dev_reset |=> pre_reg == 8'h00)
      else $error("reset left scaler nonzero");
   a_inhibit_start: assert property (write_go |=>
      inhibit_reg == timer_prescaler_pkg::INHIBIT_CYCLES)
      else $error("inhibit not armed after timer write");
   a_inhibit_holds: assert property (inhibit_on && !write_go |=> $stable(timer_count_reg))
      else $error("timer moved during inhibit");
   a_increment_cause: assert property ($changed(timer_count_reg) && !$past(write_go) |->
      $past(edge_pend_reg) && timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("timer moved without captured edge");
   a_edge_on_phase: assert property (edge_pend_reg |->
      $past(phase_reg) == timer_prescaler_pkg::PHASE_TWO ||
      $past(phase_reg) == timer_prescaler_pkg::PHASE_FOUR)
      else $error("edge captured outside phase two or four");
   a_ratio_tap: assert property (to_timer |-> timer_in == pre_reg[ratio])
      else $error("wrong scaler tap");
   a_fuse_off_quiet: assert property (!wdt_on |-> ##1 !wdt_timeout_reg)
      else $error("timeout with watchdog fused off");
   a_sleep_exit: assert property ($fell(sleeping_reg) |-> $past(wdt_fire))
      else $error("sleep left without timeout");
   a_hold_length: assert property ($fell(in_reset_reg) |->
      $past(hold_reg) == 18'(RESET_HOLD_CYCLES - 1))
      else $error("reset hold wrong length");

   c_timer_inc: cover property (edge_pend_reg && !inhibit_on ##1 $changed(timer_count_reg));
   c_ext_falling: cover property (option_reg.count_source_select &&
      option_reg.count_edge_select && edge_pend_reg);
   c_wdt_wake: cover property (sleeping_reg && wdt_fire);
   c_wdt_scaled: cover property (!to_timer && wdt_fire);

endmodule

// ### timer_prescaler_pkg.sv
package timer_prescaler_pkg;

   // timer configuration word, low six bits
   typedef struct packed {
      logic       count_source_select;     // 1 = external pin, 0 = instruction cycle
      logic       count_edge_select;       // 1 = falling pin edge counts
      logic       prescaler_assign_select; // 1 = watchdog, 0 = timer
      logic [2:0] prescale_ratio_field;    // ratio code
   } option_t;

   // configuration fuses
   typedef struct packed {
      logic       code_protect_fuse;       // 0 = protection on
      logic       watchdog_enable_fuse;    // 1 = watchdog runs
      logic [1:0] osc_type_select;         // oscillator type
   } fuse_t;

   // option word after any reset
   localparam option_t OPTION_RESET = 6'h3f;
   localparam fuse_t   FUSE_RESET   = 4'hf;

   // phase counter codes inside one instruction cycle
   localparam logic [1:0] PHASE_ONE   = 2'h0;
   localparam logic [1:0] PHASE_TWO   = 2'h1;
   localparam logic [1:0] PHASE_FOUR  = 2'h3;

   // shared scaler
   localparam int         PRE_W       = 8;
   localparam logic [7:0] PRE_ZERO    = 8'h00;

   // write inhibit, in instruction cycles
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   localparam logic [1:0] INHIBIT_NONE   = 2'h0;

   // watchdog base period in rc oscillator ticks
   localparam logic [7:0] WDT_BASE_LAST = 8'hff;
   localparam logic [7:0] WDT_ZERO      = 8'h00;

   // reset hold time
   localparam int CLK_PERIOD_NS = 100;
   localparam int HOLD_TIME_MS  = 18;
   localparam int HOLD_CYCLES   = (HOLD_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int HOLD_W        = 18;
   localparam logic [17:0] HOLD_ZERO = 18'h00000;

endpackage

// ### ext_clock_src.sv
`timescale 1ns/1ps
// outside count source driving the pin
module ext_clock_src (
   // clock
   input  wire logic ref_clk,
   // count pin
   output logic      pin
);
   // pin idles low
   initial pin = 1'b0;

   // n high pulses, half period in clocks, last level kept high if hi
   task automatic pulses(input int n, input int half, input bit hi);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk) pin <= 1'b1;
         repeat (half) @(posedge ref_clk);
         if (i < n - 1 || !hi)
            pin <= 1'b0;
         repeat (half) @(posedge ref_clk);
      end
   endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
   // clock, reset and core strobes
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       option_write = 1'b0;
   logic       timer_write = 1'b0;
   logic [7:0] timer_wdata = 8'h00;
   logic       watchdog_clear_op = 1'b0;
   logic       sleep_req = 1'b0;
   logic       wdt_osc_tick = 1'b0;
   logic       pin;
   // packed words
   timer_prescaler_pkg::option_t option_wdata = 6'h00;
   timer_prescaler_pkg::fuse_t   fuse_strap = 4'hf;
   timer_prescaler_pkg::option_t option_reg;
   timer_prescaler_pkg::fuse_t   fuse_reg;
   // status
   logic [7:0] timer_count_reg;
   logic       wdt_timeout_reg;
   logic       in_reset_reg;
   logic       sleeping_reg;
   // bench state
   int          n_fail = 0;
   int          n_compared = 0;
   int          n_to = 0;
   int unsigned seed = 31;
   int          p;
   logic [7:0]  s;

   // short hold keeps the run brief
   timer_prescaler #(.RESET_HOLD_CYCLES(8)) u_timer_prescaler (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .ext_count_clock_pin(pin),
      .option_write(option_write), .option_wdata(option_wdata),
      .timer_write(timer_write), .timer_wdata(timer_wdata),
      .watchdog_clear_op(watchdog_clear_op), .sleep_req(sleep_req),
      .wdt_osc_tick(wdt_osc_tick), .fuse_strap(fuse_strap),
      .timer_count_reg(timer_count_reg), .option_reg(option_reg),
      .fuse_reg(fuse_reg), .wdt_timeout_reg(wdt_timeout_reg),
      .in_reset_reg(in_reset_reg), .sleeping_reg(sleeping_reg));
   ext_clock_src u_ext_clock_src (.ref_clk(ref_clk), .pin(pin));

   // 100 ns clock
   always #50 ref_clk = ~ref_clk;

   // count timeout pulses
   always @(posedge ref_clk)
      if (wdt_timeout_reg === 1'b1)
         n_to++;

   // xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // exact compare
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
      n_compared++;
      if (v !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, v);
      end
   endtask

   // window compare on a count difference
   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] d);
      n_compared++;
      if ((d >= lo && d <= hi) !== 1'b1)
      begin
         n_fail++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, d);
      end
   endtask

   task automatic end_test(input string nm);
      $display("test %s done", nm);
   endtask

   // one core strobe: 0 option, 1 timer, 2 watchdog clear, 3 sleep
   task automatic op(input int k, input logic [7:0] d);
      @(posedge ref_clk);
      option_wdata <= d[5:0];
      timer_wdata <= d;
      option_write <= (k == 0);
      timer_write <= (k == 1);
      watchdog_clear_op <= (k == 2);
      sleep_req <= (k == 3);
      @(posedge ref_clk);
      {option_write, timer_write, watchdog_clear_op, sleep_req} <= 4'h0;
   endtask

   // watchdog oscillator ticks, one every other clock
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         wdt_osc_tick <= 1'b1;
         @(posedge ref_clk);
         wdt_osc_tick <= 1'b0;
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // reset, then hold and captured fuses
   task automatic do_reset(input logic [3:0] f);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      fuse_strap <= f;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wait_clk(6);
      chk("hold", 8'h01, {7'h0, in_reset_reg});
      wait_clk(6);
      chk("hold", 8'h00, {7'h0, in_reset_reg});
      chk("fuse", {4'h0, f}, {4'h0, fuse_reg});
      chk("opt", 8'h3f, {2'h0, option_reg});
      chk("tmr", 8'h00, timer_count_reg);
   endtask

   // pin pulses counted from a random start
   task automatic pin_run(input logic [7:0] o, input int n, input int h, input bit hi, input int e);
      logic [7:0] b;
      b = rnd();
      op(0, o);
      op(1, b);
      wait_clk(12);
      u_ext_clock_src.pulses(n, h, hi);
      wait_clk(12);
      chk("pin", 8'(b + e), timer_count_reg);
   endtask

   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      s = rnd();
      do_reset({s[3], 1'b1, s[1:0]});
      end_test("reset");
      // internal source unscaled: inhibit then rate
      s = rnd();
      op(0, 8'h08);
      op(1, s);
      wait_clk(4);
      chk("inhibit", s, timer_count_reg);
      wait_clk(34);
      chk_rng("rate", 7, 8, timer_count_reg - s);
      // scaler back from watchdog to timer: clear first, then option
      op(2, 8'h00);
      // every ratio code on the timer
      for (int n = 0; n < 8; n++)
      begin
         s = rnd();
         op(0, 8'(n));
         op(1, s);
         wait_clk(3 << (n + 3));
         chk_rng("ratio", 2, 3, timer_count_reg - s);
      end
      end_test("ratio");
      // timer write clears a half-full scaler
      op(0, 8'h07);
      op(1, 8'h00);
      wait_clk(400);
      op(1, 8'h55);
      wait_clk(400);
      chk("clear", 8'h55, timer_count_reg);
      end_test("clear");
      // pin edges, both polarities, then scaled
      p = 1 + int'(rnd()) % 12;
      pin_run(8'h28, p, 4, 1'b1, p);
      pin_run(8'h38, p, 2, 1'b0, p);
      pin_run(8'h20, 2 * p, 2, 1'b0, p);
      end_test("pin");
      // move scaler to watchdog, clear, timeout
      op(2, 8'h00);
      op(1, 8'h00);
      op(0, 8'h0f);
      op(2, 8'h00);
      op(0, 8'h08);
      tick(200);
      op(2, 8'h00);
      tick(255);
      chk("timeout", 8'h00, 8'(n_to));
      tick(1);
      wait_clk(4);
      chk("timeout", 8'h01, 8'(n_to));
      chk("opt", 8'h3f, {2'h0, option_reg});
      wait_clk(12);
      // sleep refuses writes, timeout wakes
      op(2, 8'h00);
      op(0, 8'h29);
      op(3, 8'h00);
      wait_clk(2);
      s = timer_count_reg;
      op(1, ~s);
      wait_clk(2);
      chk("sleep", 8'h01, {7'h0, sleeping_reg});
      chk("refused", s, timer_count_reg);
      tick(511);
      chk("sleep", 8'h01, {7'h0, sleeping_reg});
      tick(1);
      wait_clk(4);
      chk("wake", 8'h00, {7'h0, sleeping_reg});
      chk("wake", 8'h00, {7'h0, in_reset_reg});
      // fuse off stops the watchdog
      s = rnd();
      do_reset({s[3], 1'b0, s[1:0]});
      p = n_to;
      // unscaled watchdog would wrap inside these ticks if it ran
      op(0, 8'h08);
      tick(300);
      chk("disabled", 8'(p), 8'(n_to));
      end_test("watchdog");
      print_verdict();
   end
endmodule
